// ---- rtl/tes_edge_shaper.sv ----
// Type B 424 kbit/s transmitter edge shaper with AHB-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
`include "tes_defs.svh"

module tes_edge_shaper (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        modulate_in,
	input  wire logic [7:0]  power_amp_supply_in,
	output logic      [7:0]  carrier_amplitude_out,
	output logic             edge_active_out,
	output logic             reserved_style_out
);

	logic [7:0] edge_shape_select_424_reg;
	logic [7:0] edge_shape_tuning_424_reg;
	logic [7:0] edge_duration_424_reg;
	logic [7:0] residual_carrier_level_848_reg;

	logic                  wr_pend_reg;
	logic [7:0]            wr_idx_reg;
	logic                  rd_fwd;
	logic [7:0]            addr_idx;
	logic                  addr_ok;
	logic [7:0]            rd_value;

	tes_pkg::tes_state_t   state_reg;
	tes_pkg::tes_edge_cfg_t cfg_reg;
	tes_pkg::tes_edge_cfg_t fall_cfg;
	tes_pkg::tes_edge_cfg_t rise_cfg;
	logic [4:0]            step_reg;
	logic                  half_reg;
	logic [4:0]            step_next;
	logic [4:0]            last_step;
	logic [7:0]            shape_frac;
	logic [7:0]            amp_next;
	logic                  step_done;

	// Table shapes, each ending at full scale so the edge lands on target.
	localparam logic [7:0] LUT [`TES_LUT_TABLES][`TES_LUT_POINTS] = '{
		'{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'hFF},
		'{8'h04, 8'h0C, 8'h1C, 8'h38, 8'h60, 8'h98, 8'hD8, 8'hFF},
		'{8'h40, 8'h80, 8'hA8, 8'hC4, 8'hD8, 8'hE8, 8'hF4, 8'hFF},
		'{8'h08, 8'h18, 8'h40, 8'h80, 8'hC0, 8'hE8, 8'hF8, 8'hFF}
	};

	function automatic logic [7:0] interp(input logic [7:0] p,
		input logic [7:0] p0, input logic [7:0] p1,
		input logic [7:0] f0, input logic [7:0] f1);
		logic [15:0] num;
		num = 16'((f1 - f0) * (p - p0));
		if (p1 == p0) begin
			interp = f1;
		end else begin
			interp = 8'(f0 + 8'(num / {8'h00, 8'(p1 - p0)}));
		end
	endfunction : interp

	function automatic logic [7:0] lin_shape(input logic [3:0] style,
		input logic [2:0] tc, input logic [7:0] p);
		logic [7:0] k1;
		logic [7:0] k2;
		k1 = 8'(`TES_THREE_BASE_A + tc * `TES_THREE_SLOPE);
		k2 = 8'(`TES_THREE_BASE_B + tc * `TES_THREE_SLOPE);
		case (style)
			`TES_STY_FW_TWO: begin
				if (p < `TES_KNEE_HALF) begin
					lin_shape = interp(p, 8'h00, `TES_KNEE_HALF, 8'h00,
						8'(`TES_TWO_BASE + tc * `TES_TWO_SLOPE));
				end else begin
					lin_shape = interp(p, `TES_KNEE_HALF, `TES_AMP_FULL,
						8'(`TES_TWO_BASE + tc * `TES_TWO_SLOPE),
						`TES_AMP_FULL);
				end
			end
			`TES_STY_FW_THREE: begin
				if (p < `TES_KNEE_THIRD) begin
					lin_shape = interp(p, 8'h00, `TES_KNEE_THIRD, 8'h00, k1);
				end else if (p < `TES_KNEE_TWO_THIRD) begin
					lin_shape = interp(p, `TES_KNEE_THIRD,
						`TES_KNEE_TWO_THIRD, k1, k2);
				end else begin
					lin_shape = interp(p, `TES_KNEE_TWO_THIRD,
						`TES_AMP_FULL, k2, `TES_AMP_FULL);
				end
			end
			default: begin
				lin_shape = p;
			end
		endcase
	endfunction : lin_shape

	// Scales a table value by nominal over actual amplifier supply.
	function automatic logic [7:0] adapt(input logic [7:0] f,
		input logic [7:0] supply);
		logic [15:0] q;
		q = 16'h0000;
		if (supply != 8'h00) begin
			q = 16'(16'(f) * 16'(`TES_PA_NOMINAL));
			q = 16'(q / {8'h00, supply});
		end
		if (supply == 8'h00) begin
			adapt = f;
		end else if (q > 16'(`TES_AMP_FULL)) begin
			adapt = `TES_AMP_FULL;
		end else begin
			adapt = q[7:0];
		end
	endfunction : adapt

	function automatic logic [7:0] mix(input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] f);
		logic [15:0] d;
		if (b >= a) begin
			d = 16'((b - a) * f);
			mix = 8'(a + 8'(d / 16'(`TES_AMP_FULL)));
		end else begin
			d = 16'((a - b) * f);
			mix = 8'(a - 8'(d / 16'(`TES_AMP_FULL)));
		end
	endfunction : mix

	function automatic logic reserved_code(input logic [3:0] s);
		reserved_code = (s < `TES_STY_FW_ONE) || (s > `TES_STY_LUT_NOCORR);
	endfunction : reserved_code

	// Bus decode: one aligned word per register, byte address is 4 x index.
	assign addr_idx = haddr_in[`TES_ADDR_MSB:`TES_ADDR_LSB];
	assign addr_ok  = (haddr_in[31:`TES_ADDR_MSB+1] == '0)
		&& (haddr_in[1:0] == 2'h0);
	assign rd_fwd   = wr_pend_reg && (wr_idx_reg == addr_idx);

	always_comb begin
		case (addr_idx)
			`TES_IDX_SELECT:   rd_value = edge_shape_select_424_reg;
			`TES_IDX_TUNING:   rd_value = edge_shape_tuning_424_reg;
			`TES_IDX_DURATION: rd_value = edge_duration_424_reg;
			`TES_IDX_RESIDUAL: rd_value = residual_carrier_level_848_reg;
			default:           rd_value = 8'h00;
		endcase
		if (rd_fwd) begin
			case (addr_idx)
				`TES_IDX_TUNING:
					rd_value = hwdata_in[7:0] & `TES_MASK_TUNING;
				`TES_IDX_DURATION:
					rd_value = hwdata_in[7:0] & `TES_MASK_DURATION;
				`TES_IDX_SELECT, `TES_IDX_RESIDUAL:
					rd_value = hwdata_in[7:0];
				default:
					rd_value = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
		end else if (hready_in) begin
			wr_pend_reg <= hsel_in && htrans_in[1] && hwrite_in && addr_ok;
			wr_idx_reg  <= addr_idx;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
			if (!addr_ok) begin
				hrdata_out <= 32'h0000_0000;
			end else if (addr_idx == `TES_IDX_STATUS) begin
				hrdata_out <= {16'h0000, carrier_amplitude_out, 3'h0,
					reserved_style_out, edge_active_out, 1'b0, state_reg};
			end else begin
				hrdata_out <= {24'h00_0000, rd_value};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b0;
			hresp_out     <= 1'b0;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			edge_shape_select_424_reg      <= `TES_RST_SELECT;
			edge_shape_tuning_424_reg      <= `TES_RST_TUNING;
			edge_duration_424_reg          <= `TES_RST_DURATION;
			residual_carrier_level_848_reg <= `TES_RST_RESIDUAL;
		end else if (wr_pend_reg) begin
			case (wr_idx_reg)
				`TES_IDX_SELECT:
					edge_shape_select_424_reg <= hwdata_in[7:0];
				`TES_IDX_TUNING:
					edge_shape_tuning_424_reg <=
						hwdata_in[7:0] & `TES_MASK_TUNING;
				`TES_IDX_DURATION:
					edge_duration_424_reg <=
						hwdata_in[7:0] & `TES_MASK_DURATION;
				`TES_IDX_RESIDUAL:
					residual_carrier_level_848_reg <= hwdata_in[7:0];
				default: begin
				end
			endcase
		end
	end

	// Edge settings as they would be captured at the start of each edge.
	always_comb begin
		fall_cfg.style     = edge_shape_select_424_reg[`TES_SEL_FALL];
		fall_cfg.tune      = edge_shape_tuning_424_reg[`TES_TUNE_FALL];
		fall_cfg.doubled   = edge_duration_424_reg[`TES_DUR_DOUBLE];
		fall_cfg.states    = edge_duration_424_reg[`TES_DUR_STATES];
		fall_cfg.start_amp = carrier_amplitude_out;
		fall_cfg.end_amp   = residual_carrier_level_848_reg;
		rise_cfg           = fall_cfg;
		rise_cfg.style     = edge_shape_select_424_reg[`TES_SEL_RISE];
		rise_cfg.tune      = edge_shape_tuning_424_reg[`TES_TUNE_RISE];
		rise_cfg.end_amp   = `TES_AMP_FULL;
	end

	// A state count of zero still runs one state.
	assign last_step = (cfg_reg.states == 5'h00) ? 5'h01 : cfg_reg.states;
	assign step_next = 5'(step_reg + 5'h01);
	assign step_done = !cfg_reg.doubled || half_reg;

	always_comb begin
		logic [7:0] p;
		logic [7:0] t;
		p = 8'(13'({step_next, 8'h00} - {8'h00, step_next})
			/ 13'({8'h00, last_step}));
		t = LUT[cfg_reg.tune[1:0]][p[7:5]];
		case (cfg_reg.style)
			`TES_STY_FW_ONE, `TES_STY_FW_TWO, `TES_STY_FW_THREE:
				shape_frac = lin_shape(cfg_reg.style, cfg_reg.tune, p);
			`TES_STY_LUT_PLAIN:
				shape_frac = t;
			`TES_STY_LUT_CORR: begin
				shape_frac = (step_next >= last_step) ? `TES_AMP_FULL
					: adapt(t, power_amp_supply_in);
			end
			`TES_STY_LUT_NOCORR:
				shape_frac = adapt(t, power_amp_supply_in);
			default:
				shape_frac = `TES_AMP_FULL;
		endcase
		amp_next = mix(cfg_reg.start_amp, cfg_reg.end_amp, shape_frac);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg             <= tes_pkg::TES_HOLD_FULL;
			cfg_reg               <= '0;
			step_reg              <= 5'h00;
			half_reg              <= 1'b0;
			carrier_amplitude_out <= `TES_AMP_FULL;
			edge_active_out       <= 1'b0;
		end else begin
			case (state_reg)
				tes_pkg::TES_HOLD_FULL: begin
					if (modulate_in) begin
						cfg_reg         <= fall_cfg;
						step_reg        <= 5'h00;
						half_reg        <= 1'b0;
						edge_active_out <= 1'b1;
						state_reg       <= tes_pkg::TES_FALLING;
					end
				end
				tes_pkg::TES_HOLD_LOW: begin
					if (!modulate_in) begin
						cfg_reg         <= rise_cfg;
						step_reg        <= 5'h00;
						half_reg        <= 1'b0;
						edge_active_out <= 1'b1;
						state_reg       <= tes_pkg::TES_RISING;
					end
				end
				tes_pkg::TES_FALLING, tes_pkg::TES_RISING: begin
					half_reg <= cfg_reg.doubled && !half_reg;
					if (step_done) begin
						carrier_amplitude_out <= amp_next;
						step_reg              <= step_next;
						if (step_next >= last_step ||
							reserved_code(cfg_reg.style)) begin
							edge_active_out <= 1'b0;
							state_reg <= (state_reg == tes_pkg::TES_FALLING)
								? tes_pkg::TES_HOLD_LOW
								: tes_pkg::TES_HOLD_FULL;
						end
					end
				end
				default: begin
					state_reg <= tes_pkg::TES_HOLD_FULL;
				end
			endcase
		end
	end

	// Flags that the edge in progress, or the last one, used a reserved code.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reserved_style_out <= 1'b0;
		end else if (state_reg == tes_pkg::TES_HOLD_FULL && modulate_in) begin
			reserved_style_out <= reserved_code(fall_cfg.style);
		end else if (state_reg == tes_pkg::TES_HOLD_LOW && !modulate_in) begin
			reserved_style_out <= reserved_code(rise_cfg.style);
		end
	end

endmodule : tes_edge_shaper
`default_nettype wire

// ---- rtl/tes_defs.svh ----
// Offsets, field positions, reset values and constants of the edge shaper.
`ifndef TES_DEFS_SVH
`define TES_DEFS_SVH

// Register indices; the byte address is four times the index.
`define TES_IDX_SELECT     8'h2D
`define TES_IDX_TUNING     8'h2E
`define TES_IDX_DURATION   8'h2F
`define TES_IDX_RESIDUAL   8'h30
`define TES_IDX_STATUS     8'h3F
`define TES_ADDR_LSB       2
`define TES_ADDR_MSB       9

// Field positions.
`define TES_SEL_FALL       7:4
`define TES_SEL_RISE       3:0
`define TES_TUNE_FALL      6:4
`define TES_TUNE_RISE      2:0
`define TES_DUR_DOUBLE     7
`define TES_DUR_STATES     4:0

// Writable bit masks; the remaining bits are reserved and read as zero.
`define TES_MASK_TUNING    8'h77
`define TES_MASK_DURATION  8'h9F

// Reset values.
`define TES_RST_SELECT     8'h11
`define TES_RST_TUNING     8'h00
`define TES_RST_DURATION   8'h08
`define TES_RST_RESIDUAL   8'h20

// Style codes.
`define TES_STY_FW_ONE     4'h1
`define TES_STY_FW_TWO     4'h2
`define TES_STY_FW_THREE   4'h3
`define TES_STY_LUT_PLAIN  4'h4
`define TES_STY_LUT_CORR   4'h5
`define TES_STY_LUT_NOCORR 4'h6

// Amplitude levels and shaping constants.
`define TES_AMP_FULL       8'hFF
`define TES_PA_NOMINAL     8'h80
`define TES_KNEE_HALF      8'h80
`define TES_KNEE_THIRD     8'h55
`define TES_KNEE_TWO_THIRD 8'hAA
`define TES_TWO_BASE       8'h40
`define TES_TWO_SLOPE      8'h10
`define TES_THREE_BASE_A   8'h20
`define TES_THREE_BASE_B   8'h90
`define TES_THREE_SLOPE    8'h08
`define TES_LUT_TABLES     4
`define TES_LUT_POINTS     8

`endif

// ---- rtl/tes_pkg.sv ----
// Types shared by the edge shaper.
`default_nettype none
package tes_pkg;

	typedef enum logic [1:0] {
		TES_HOLD_FULL,
		TES_FALLING,
		TES_HOLD_LOW,
		TES_RISING
	} tes_state_t;

	// Settings captured at the start of one edge.
	typedef struct packed {
		logic [3:0] style;
		logic [2:0] tune;
		logic       doubled;
		logic [4:0] states;
		logic [7:0] start_amp;
		logic [7:0] end_amp;
	} tes_edge_cfg_t;

endpackage : tes_pkg
`default_nettype wire

// ---- verification/tes_edge_shaper_assertions.sv ----
// Port assertions for the edge shaper.
`timescale 1ns/100ps
`default_nettype none
`include "tes_defs.svh"

module tes_edge_shaper_checker (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic        hready_in,
	input wire logic [31:0] hrdata_out,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic [7:0]  carrier_amplitude_out,
	input wire logic        edge_active_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	logic rd;
	logic hit;
	assign rd = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
	assign hit = haddr_in[9:2] inside {`TES_IDX_SELECT, `TES_IDX_TUNING,
		`TES_IDX_DURATION, `TES_IDX_RESIDUAL, `TES_IDX_STATUS};

	sequence idle_two;
		!edge_active_out ##1 !edge_active_out;
	endsequence

	okay_resp_a: assert property (hresp_out == 1'b0)
		else $error("hresp not okay");
	zero_wait_a: assert property (!$past(rst_in) |-> hreadyout_out)
		else $error("wait state inserted");
	upper_zero_a: assert property (rd |=> hrdata_out[31:16] == 16'h0000)
		else $error("upper read bits set");
	unmapped_zero_a: assert property (rd && haddr_in[31:10] == 22'h0 &&
		haddr_in[1:0] == 2'h0 && !hit |=> hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	status_mirror_a: assert property (rd && hit &&
		haddr_in[9:2] == `TES_IDX_STATUS |=>
		hrdata_out[15:8] == $past(carrier_amplitude_out) &&
		hrdata_out[3] == $past(edge_active_out))
		else $error("status does not mirror outputs");
	rdata_stands_a: assert property (!rd |=> $stable(hrdata_out))
		else $error("read data moved");
	amp_hold_a: assert property (idle_two |-> $stable(carrier_amplitude_out))
		else $error("amplitude moved outside an edge");
	start_flat_a: assert property ($rose(edge_active_out) |->
		$stable(carrier_amplitude_out))
		else $error("amplitude moved at edge start");
	edge_bound_a: assert property ($rose(edge_active_out) |-> ##[1:62] !edge_active_out)
		else $error("edge too long");
endmodule : tes_edge_shaper_checker

bind tes_edge_shaper tes_edge_shaper_checker chk_u (.clk_in, .rst_in,
	.hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
	.hreadyout_out, .hresp_out, .carrier_amplitude_out, .edge_active_out);

`default_nettype wire

// ---- verification/tes_edge_shaper_bench.sv ----
// Register and edge tests for the edge shaper.
`timescale 1ns/100ps
`default_nettype none
`include "tes_defs.svh"

module tes_edge_shaper_bench;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        hsel_in = 1'b0;
	logic        hwrite_in = 1'b0;
	logic        modulate_in = 1'b0;
	logic [1:0]  htrans_in = 2'b00;
	logic [2:0]  hsize_in = 3'h2;
	logic [31:0] haddr_in = 32'h0;
	logic [31:0] hwdata_in = 32'h0;
	logic [7:0]  power_amp_supply_in = 8'h80;
	logic [31:0] hrdata_out;
	logic [31:0] rd;
	logic [31:0] sig;
	logic [31:0] s [8];
	logic [7:0]  carrier_amplitude_out;
	logic [7:0]  amp;
	logic [7:0]  fall_amp;
	logic        hreadyout_out;
	logic        hresp_out;
	logic        edge_active_out;
	logic        reserved_style_out;
	logic        rsv;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cyc;
	int          i;

	always #25 clk_in = ~clk_in;

	tes_edge_shaper dut_u (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
		.hwrite_in, .hsize_in, .hready_in(hreadyout_out), .hwdata_in,
		.hrdata_out, .hreadyout_out, .hresp_out, .modulate_in,
		.power_amp_supply_in, .carrier_amplitude_out, .edge_active_out,
		.reserved_style_out);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] x, input logic [31:0] d);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'b10;
		haddr_in <= {22'h0, x, 2'b00};
		hwrite_in <= w;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= d;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask : bus

	task automatic rchk(input logic [7:0] x, input logic [31:0] exp);
		bus(1'b0, x, 32'h0);
		chk(rd, exp);
	endtask : rchk

	task automatic edge_run(input logic mod, input logic flip);
		int t;
		t = 0;
		@(posedge clk_in);
		modulate_in <= mod;
		while (edge_active_out !== 1'b1 && t < 100) begin
			@(posedge clk_in);
			t++;
		end
		cyc = 0;
		sig = 32'h0;
		while (edge_active_out === 1'b1 && cyc < 100) begin
			cyc++;
			sig = {sig[30:0], sig[31]} ^ {24'h0, carrier_amplitude_out};
			if (flip && cyc == 2) modulate_in <= !mod;
			@(posedge clk_in);
		end
		amp = carrier_amplitude_out;
	endtask : edge_run

	// Signature of a falling and rising edge pair under one setting.
	task automatic sig_of(input logic [7:0] sel, input logic [7:0] tu,
		input logic [7:0] su, output logic [31:0] o);
		bus(1'b1, `TES_IDX_SELECT, {24'h0, sel});
		bus(1'b1, `TES_IDX_TUNING, {24'h0, tu});
		@(posedge clk_in);
		power_amp_supply_in <= su;
		edge_run(1'b1, 1'b0);
		o = sig;
		fall_amp = amp;
		edge_run(1'b0, 1'b0);
		o = o ^ {sig[15:0], sig[31:16]};
	endtask : sig_of

	task automatic wrap_up;
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	initial begin
		#2000000;
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rchk(`TES_IDX_SELECT, 32'h11);
		rchk(`TES_IDX_TUNING, 32'h00);
		rchk(`TES_IDX_DURATION, 32'h08);
		rchk(`TES_IDX_RESIDUAL, 32'h20);
		rchk(`TES_IDX_STATUS, 32'h0000FF00);
		bus(1'b1, 8'h40, 32'hFF);
		rchk(8'h40, 32'h0);
		bus(1'b1, `TES_IDX_STATUS, 32'hFFFFFFFF);
		rchk(`TES_IDX_STATUS, 32'h0000FF00);
		bus(1'b1, `TES_IDX_TUNING, 32'hFFFFFFFF);
		rchk(`TES_IDX_TUNING, 32'h77);
		bus(1'b1, `TES_IDX_DURATION, 32'hFF);
		rchk(`TES_IDX_DURATION, 32'h9F);
		bus(1'b1, `TES_IDX_SELECT, 32'hA5);
		rchk(`TES_IDX_SELECT, 32'hA5);
		bus(1'b1, `TES_IDX_TUNING, 32'h11);
		bus(1'b1, `TES_IDX_DURATION, 32'h03);
		for (i = 0; i < 8; i++) begin
			rsv = (i == 0 || i == 7);
			bus(1'b1, `TES_IDX_SELECT, {24'h0, i[3:0], i[3:0]});
			edge_run(1'b1, 1'b0);
			chk(cyc, rsv ? 1 : 3);
			chk(reserved_style_out, rsv);
			if (i != 4 && i != 6) chk(amp, 32'h20);
			edge_run(1'b0, 1'b0);
			chk(cyc, rsv ? 1 : 3);
			if (i != 4 && i != 6) chk(amp, 32'hFF);
		end
		bus(1'b1, `TES_IDX_SELECT, 32'h11);
		bus(1'b1, `TES_IDX_DURATION, 32'h83);
		edge_run(1'b1, 1'b0);
		chk(cyc, 6);
		bus(1'b1, `TES_IDX_DURATION, 32'h80);
		edge_run(1'b0, 1'b0);
		chk(cyc, 2);
		bus(1'b1, `TES_IDX_DURATION, 32'h9F);
		edge_run(1'b1, 1'b0);
		chk(cyc, 62);
		bus(1'b1, `TES_IDX_DURATION, 32'h08);
		edge_run(1'b0, 1'b1);
		chk(cyc, 8);
		chk(amp, 32'hFF);
		edge_run(1'b1, 1'b0);
		chk(cyc, 8);
		chk(amp, 32'h20);
		edge_run(1'b0, 1'b0);
		for (i = 0; i < 2; i++) begin
			bus(1'b1, `TES_IDX_RESIDUAL, {24'h0, {8{i[0]}}});
			edge_run(1'b1, 1'b0);
			chk(amp, {24'h0, {8{i[0]}}});
			edge_run(1'b0, 1'b0);
		end
		bus(1'b1, `TES_IDX_RESIDUAL, 32'h20);
		sig_of(8'h44, 8'h11, 8'h80, s[0]);
		sig_of(8'h44, 8'h11, 8'h40, s[1]);
		chk(s[1], s[0]);
		sig_of(8'h44, 8'h22, 8'h40, s[2]);
		chk(s[2] !== s[1], 1);
		sig_of(8'h44, 8'h12, 8'h40, s[3]);
		chk(s[3] !== s[1], 1);
		sig_of(8'h66, 8'h11, 8'h80, s[4]);
		sig_of(8'h66, 8'h11, 8'h40, s[5]);
		chk(s[5] !== s[4], 1);
		sig_of(8'h55, 8'h11, 8'hFF, s[6]);
		chk(fall_amp, 32'h20);
		sig_of(8'h22, 8'h00, 8'h80, s[6]);
		sig_of(8'h22, 8'h30, 8'h80, s[7]);
		chk(s[7] !== s[6], 1);
		sig_of(8'h22, 8'h03, 8'h80, s[7]);
		chk(s[7] !== s[6], 1);
		wrap_up();
	end
endmodule : tes_edge_shaper_bench

`default_nettype wire
